// [src/eas_pair_if.sv]
`timescale 1ns/1ps
// link events into one pair tracker and its status back
interface eas_pair_if;
   logic field_tick; // one pulse per video field
   logic hit; // packet seen for this pair
   logic is_data; // packet carried data, not audio
   logic locked; // packet was synchronous to video
   logic [1:0] kind; // reported content code
   logic sync; // reported synchronous flag
   modport ctl (output field_tick, output hit, output is_data, output locked,
      input kind, input sync);
   modport trk (input field_tick, input hit, input is_data, input locked,
      output kind, output sync);
endinterface

// [src/eas_pair_trk.sv]
`timescale 1ns/1ps
// tracks content of one incoming channel pair
module eas_pair_trk
   import eas_pkg::*;
#(
   parameter int MISS = EAS_MISS_FIELDS
) (
   input wire logic pclk,
   input wire logic presetn,
   eas_pair_if.trk p
);
   // ====================
   // state
   eas_pair_e st_q, st_d; // current content
   logic sync_q; // last packet lock
   logic [3:0] miss_q; // fields without a packet
   wire miss_out = (miss_q >= 4'(MISS)); // content has gone away

   // next content state
   always_comb begin
      st_d = st_q;
      case (st_q)
         EAS_PS_NONE: begin
            if (p.hit) begin
               st_d = p.is_data ? EAS_PS_DATA : EAS_PS_AUDIO;
            end
         end
         EAS_PS_AUDIO, EAS_PS_DATA: begin
            if (p.hit) begin
               st_d = p.is_data ? EAS_PS_DATA : EAS_PS_AUDIO;
            end else if (miss_out) begin
               st_d = EAS_PS_NONE;
            end
         end
         default: st_d = EAS_PS_NONE;
      endcase
   end

   // registers and miss counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= EAS_PS_NONE;
         sync_q <= 1'b0;
         miss_q <= 4'h0;
      end else begin
         st_q <= st_d;
         if (p.hit) begin
            sync_q <= p.locked;
            miss_q <= 4'h0;
         end else if (p.field_tick && !miss_out) begin
            miss_q <= miss_q + 4'h1;
         end
      end
   end

   // three distinct codes
   assign p.kind = (st_q == EAS_PS_DATA) ? EAS_KIND_DATA : // RQ2
      (st_q == EAS_PS_AUDIO) ? EAS_KIND_AUDIO : EAS_KIND_NONE;
   assign p.sync = (st_q != EAS_PS_NONE) && sync_q; // RQ3
endmodule

// [src/eas_pkg.sv]
package eas_pkg;
   // ====================
   // register byte offsets
   localparam logic [7:0] EAS_OFF_CTRL = 8'h00;
   localparam logic [7:0] EAS_OFF_ANLG = 8'h04;
   localparam logic [7:0] EAS_OFF_DELAY = 8'h08;
   localparam logic [7:0] EAS_OFF_KIND = 8'h0c;
   localparam logic [7:0] EAS_OFF_STAT = 8'h10;
   // ====================
   // register field positions
   localparam int EAS_CTRL_STRIP = 0;
   localparam int EAS_CTRL_DBFS = 1;
   localparam int EAS_CTRL_PRE = 2;
   localparam int EAS_CTRL_DREF = 3;
   localparam int EAS_CTRL_EMB = 4;
   localparam int EAS_ANLG_SRC12 = 0;
   localparam int EAS_ANLG_SRC34 = 4;
   localparam int EAS_ANLG_REF = 8;
   localparam int EAS_STAT_HD = 8;
   localparam int EAS_STAT_VID = 9;
   localparam int EAS_STAT_CONFL = 10;
   // ====================
   // reset values
   localparam logic [7:0] EAS_CTRL_RST = 8'h00;
   localparam logic [2:0] EAS_SRC12_RST = 3'h0;
   localparam logic [2:0] EAS_SRC34_RST = 3'h1;
   localparam logic signed [4:0] EAS_REF_RST = 5'sh04;
   localparam logic [9:0] EAS_DELAY_RST = 10'h000;
   // ====================
   // limits
   localparam logic signed [4:0] EAS_REF_MIN = -5'sd10;
   localparam logic signed [4:0] EAS_REF_MAX = 5'sd4;
   localparam logic [9:0] EAS_DELAY_MAX_MS = 10'd1000;
   localparam int EAS_MISS_FIELDS = 2;
   // ====================
   // pair content codes
   localparam logic [1:0] EAS_KIND_NONE = 2'h0;
   localparam logic [1:0] EAS_KIND_AUDIO = 2'h1;
   localparam logic [1:0] EAS_KIND_DATA = 2'h2;
   typedef enum logic [2:0] {
      EAS_PS_NONE = 3'b001,
      EAS_PS_AUDIO = 3'b010,
      EAS_PS_DATA = 3'b100
   } eas_pair_e;
endpackage

// [src/eas_top.sv]
`timescale 1ns/1ps
// What this block does
// RQ1 - accepts HD and SD serial video streams
// RQ2 - reports each pair as data, audio, none
// RQ3 - reports pair sync state or no input
// RQ4 - strip setting deletes all incoming embedded audio
// RQ5 - host avoids embedding onto an occupied group
// RQ6 - two analog pairs from selectable mixer pairs
// RQ7 - analog and digital outputs run together
// RQ8 - analog reference level from -10 to +4 dB
// RQ9 - digital reference level -20 or -18 dBFS
// RQ10 - audio delay 0 to 1000 ms
// RQ11 - scale selects LKFS or dBFS metering and gain
// RQ12 - pre-fader meters source, post-fader meters mix
// RQ13 - meter point defaults to post-fader
// RQ14 - remote settings held in own storage
// RQ15 - embed group n carries mixer channels 4n-3..4n
module eas_top
   import eas_pkg::*;
#(
   parameter int SW = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link from the video source, asynchronous to pclk
   input wire logic lnk_clk,
   input wire logic lnk_valid,
   input wire logic [2:0] lnk_pair,
   input wire logic lnk_is_data,
   input wire logic lnk_locked,
   input wire logic lnk_field,
   input wire logic lnk_hd,
   input wire logic lnk_video,
   input wire logic [SW-1:0] lnk_data,
   // packets kept after stripping
   output logic pass_valid,
   output logic [2:0] pass_pair,
   output logic pass_is_data,
   output logic [SW-1:0] pass_data,
   // mixer samples, same clock
   input wire logic mix_valid,
   input wire logic [3:0] mix_ch,
   input wire logic [SW-1:0] mix_src,
   input wire logic [SW-1:0] mix_out,
   // embed, digital and analog outputs
   output logic emb_valid,
   output logic [3:0] emb_ch,
   output logic [SW-1:0] emb_data,
   output logic aes_valid,
   output logic [3:0] aes_ch,
   output logic [SW-1:0] aes_data,
   output logic [1:0] anlg_valid,
   output logic anlg_right,
   output logic [SW-1:0] anlg_data,
   // metering tap and level settings
   output logic meter_valid,
   output logic [SW-1:0] meter_data,
   output logic meter_dbfs,
   output logic dig_ref_18,
   output logic signed [4:0] anlg_ref_db,
   output logic [9:0] delay_ms
);
   // ====================
   // link input synchronisers
   // link clock and pins are asynchronous,
   // so all pass two flops before any use
   localparam int LW = 10 + SW; // bundled link width
   logic [LW-1:0] l1_q, l2_q; // first and second stage
   logic lclk_d_q; // delayed synced link clock
   wire [LW-1:0] lraw = {lnk_clk, lnk_valid, lnk_pair, lnk_is_data,
      lnk_locked, lnk_field, lnk_hd, lnk_video, lnk_data};
   wire l_clk = l2_q[LW-1]; // synced link clock
   wire l_valid = l2_q[LW-2];
   wire [2:0] l_pair = l2_q[LW-3:LW-5];
   wire l_is_data = l2_q[LW-6];
   wire l_locked = l2_q[LW-7];
   wire l_field = l2_q[LW-8];
   wire l_hd = l2_q[LW-9];
   wire l_video = l2_q[LW-10];
   wire [SW-1:0] l_data = l2_q[SW-1:0];
   // all pins share the same two flops, so the bundle seen
   // at a detected edge is one coherent snapshot
   // the source holds pins 32 ns either side of its edge
   wire l_edge = l_clk && !lclk_d_q; // rising link clock edge
   wire l_take = l_edge && l_valid; // a packet arrives

   // delayed copy resets low like the idle link clock,
   // so no false edge follows reset
   // two-flop sync of every link pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l1_q <= '0;
         l2_q <= '0;
         lclk_d_q <= 1'b0;
      end else begin
         l1_q <= lraw;
         l2_q <= l1_q;
         lclk_d_q <= l_clk;
      end
   end

   // ====================
   // settings registers
   logic strip_q, dbfs_q, pre_q, dref_q; // control bits
   logic [3:0] emb_en_q; // embed group enables
   logic [2:0] src12_q, src34_q; // analog pair sources
   logic signed [4:0] ref_q; // analog reference dB
   logic [9:0] dly_q; // audio delay ms
   logic confl_q; // embed onto occupied group
   logic hd_q, vid_q; // input rate and presence

   // ====================
   // apb decode
   // one aligned word per register; other offsets
   // answer with an error and change nothing
   wire acc = psel && penable; // access phase
   wire done = acc && pready; // transfer completes here
   wire hit_ctrl = (paddr == EAS_OFF_CTRL);
   wire hit_anlg = (paddr == EAS_OFF_ANLG);
   wire hit_dly = (paddr == EAS_OFF_DELAY);
   wire hit_kind = (paddr == EAS_OFF_KIND);
   wire hit_stat = (paddr == EAS_OFF_STAT);
   wire mapped = hit_ctrl || hit_anlg || hit_dly || hit_kind || hit_stat;
   wire wr = done && pwrite && mapped; // write strobe
   // out-of-range writes are clamped, not refused,
   // so outputs never hold an undefined setting
   wire signed [4:0] wref = pwdata[EAS_ANLG_REF+:5]; // requested ref
   wire signed [4:0] ref_clip = (wref < EAS_REF_MIN) ? EAS_REF_MIN : // RQ8
      (wref > EAS_REF_MAX) ? EAS_REF_MAX : wref;
   wire [9:0] dly_clip = (pwdata[31:10] != 22'h0) ? EAS_DELAY_MAX_MS : // RQ10
      (pwdata[9:0] > EAS_DELAY_MAX_MS) ? EAS_DELAY_MAX_MS : pwdata[9:0];

   // ====================
   // pair trackers
   // one tracker per incoming pair; pair i holds
   // channels 2i+1, 2i+2; pairs 2g, 2g+1 form group g
   eas_pair_if pif [8] (); // one carrier per pair
   logic [15:0] kinds; // packed content codes
   logic [7:0] syncs; // packed sync flags
   for (genvar i = 0; i < 8; i++) begin : g_pair
      assign pif[i].field_tick = l_edge && l_field;
      assign pif[i].hit = l_take && (l_pair == 3'(i));
      assign pif[i].is_data = l_is_data;
      assign pif[i].locked = l_locked;
      assign kinds[2*i+:2] = pif[i].kind; // RQ2
      assign syncs[i] = pif[i].sync; // RQ3
      eas_pair_trk u_trk (
         .pclk(pclk),
         .presetn(presetn),
         .p(pif[i])
      );
   end

   // group occupied when any of its pairs holds content
   wire [3:0] grp_busy = {|kinds[15:12], |kinds[11:8], |kinds[7:4], |kinds[3:0]};
   // strip set clears the clash flag; only audio of the old group goes
   wire conflict = |(emb_en_q & grp_busy) && !strip_q; // RQ5

   // read mux
   // unused bits read zero; reads have no side effect
   wire [31:0] rd_ctrl = {24'h0, emb_en_q, dref_q, pre_q, dbfs_q, strip_q};
   wire [31:0] rd_anlg = {19'h0, ref_q, 1'b0, src34_q, 1'b0, src12_q};
   wire [31:0] rd_stat = {21'h0, confl_q, vid_q, hd_q, syncs};
   wire [31:0] rd_val = hit_ctrl ? rd_ctrl : hit_anlg ? rd_anlg :
      hit_dly ? {22'h0, dly_q} : hit_kind ? {16'h0, kinds} :
      hit_stat ? rd_stat : 32'h0;

   // apb answer, one wait state
   // pready rises in the second access cycle and falls
   // the next, giving one completing edge per transfer
   // read data and error stand only in that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= acc && !pready;
         prdata <= (acc && !pready && !pwrite) ? rd_val : 32'h0;
         pslverr <= acc && !pready && !mapped;
      end
   end

   // meter point resets to post-fader; only a reset
   // loses a setting, standing in for own storage
   // settings kept until reset or rewrite
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {emb_en_q, dref_q, pre_q, dbfs_q, strip_q} <= EAS_CTRL_RST; // RQ13
         src12_q <= EAS_SRC12_RST;
         src34_q <= EAS_SRC34_RST;
         ref_q <= EAS_REF_RST;
         dly_q <= EAS_DELAY_RST;
      end else if (wr && hit_ctrl) begin
         strip_q <= pwdata[EAS_CTRL_STRIP]; // RQ14
         dbfs_q <= pwdata[EAS_CTRL_DBFS];
         pre_q <= pwdata[EAS_CTRL_PRE];
         dref_q <= pwdata[EAS_CTRL_DREF];
         emb_en_q <= pwdata[EAS_CTRL_EMB+:4];
      end else if (wr && hit_anlg) begin
         src12_q <= pwdata[EAS_ANLG_SRC12+:3]; // RQ6
         src34_q <= pwdata[EAS_ANLG_SRC34+:3];
         ref_q <= ref_clip; // RQ8
      end else if (wr && hit_dly) begin
         dly_q <= dly_clip; // RQ10
      end
   end

   // input status flags
   // rate and video are levels, so the lag behind
   // the sync stages is harmless
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hd_q <= 1'b0;
         vid_q <= 1'b0;
         confl_q <= 1'b0;
      end else begin
         hd_q <= l_hd; // RQ1
         vid_q <= l_video;
         confl_q <= conflict;
      end
   end

   // ====================
   // incoming stream, audio stripped on request
   // data passes in either strip setting; audio is deleted here before
   // anything can re-embed it; no video passes nothing
   // while the trackers keep reporting
   wire keep = l_take && !(strip_q && !l_is_data); // RQ4

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pass_valid <= 1'b0;
         pass_pair <= 3'h0;
         pass_is_data <= 1'b0;
         pass_data <= '0;
      end else begin
         pass_valid <= keep && l_video; // RQ1
         if (keep) begin
            pass_pair <= l_pair;
            pass_is_data <= l_is_data;
            pass_data <= l_data;
         end
      end
   end

   // ====================
   // mixer output routing
   // embed group g takes mixer channels 4g to 4g+3
   // an analog pair takes the mixer pair matching its source
   // metering taps before the fader or after the mix
   wire emb_go = mix_valid && emb_en_q[mix_ch[3:2]]; // RQ15
   wire an12 = mix_valid && (mix_ch[3:1] == src12_q); // RQ6
   wire an34 = mix_valid && (mix_ch[3:1] == src34_q);
   wire [SW-1:0] meter_pick = pre_q ? mix_src : mix_out; // RQ12

   // digital, embed and analog paths in parallel
   // digital takes every sample, so both paths run
   // at once; embed and analog only filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         emb_valid <= 1'b0;
         emb_ch <= 4'h0;
         emb_data <= '0;
         aes_valid <= 1'b0;
         aes_ch <= 4'h0;
         aes_data <= '0;
         anlg_valid <= 2'b00;
         anlg_right <= 1'b0;
         anlg_data <= '0;
      end else begin
         emb_valid <= emb_go; // RQ15
         emb_ch <= mix_ch;
         emb_data <= mix_out;
         aes_valid <= mix_valid; // RQ7
         aes_ch <= mix_ch;
         aes_data <= mix_out;
         anlg_valid <= {an34, an12}; // RQ7
         anlg_right <= mix_ch[0];
         anlg_data <= mix_out;
      end
   end

   // metering tap and level settings to the audio engine
   // settings re-registered so each output is a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meter_valid <= 1'b0;
         meter_data <= '0;
         meter_dbfs <= 1'b0;
         dig_ref_18 <= 1'b0;
         anlg_ref_db <= EAS_REF_RST;
         delay_ms <= EAS_DELAY_RST;
      end else begin
         meter_valid <= mix_valid;
         meter_data <= meter_pick; // RQ12
         meter_dbfs <= dbfs_q; // RQ11
         dig_ref_18 <= dref_q; // RQ9
         anlg_ref_db <= ref_q; // RQ8
         delay_ms <= dly_q; // RQ10
      end
   end
endmodule

// [verif/eas_assertions.sv]
`timescale 1ns/1ps
// ====================
// checker on the top ports
module eas_checker
   import eas_pkg::*;
#(
   parameter int SW = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic mix_valid,
   input wire logic [3:0] mix_ch,
   input wire logic [SW-1:0] mix_src,
   input wire logic [SW-1:0] mix_out,
   input wire logic pass_valid,
   input wire logic pass_is_data,
   input wire logic emb_valid,
   input wire logic aes_valid,
   input wire logic [3:0] aes_ch,
   input wire logic [SW-1:0] aes_data,
   input wire logic [1:0] anlg_valid,
   input wire logic meter_valid,
   input wire logic [SW-1:0] meter_data,
   input wire logic meter_dbfs,
   input wire logic dig_ref_18,
   input wire logic signed [4:0] anlg_ref_db,
   input wire logic [9:0] delay_ms
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // writes that land at this edge
   wire wr = psel & penable & pwrite & pready;
   wire wr_ctrl = wr & (paddr == EAS_OFF_CTRL);
   wire wr_anlg = wr & (paddr == EAS_OFF_ANLG);
   wire wr_dly = wr & (paddr == EAS_OFF_DELAY);
   wire dly_big = (pwdata[31:10] != 22'h0) || (pwdata[9:0] > EAS_DELAY_MAX_MS);
   wire [9:0] dly_w = dly_big ? EAS_DELAY_MAX_MS : pwdata[9:0];
   logic [7:0] ctrl_q; // shadow of control word
   logic [2:0] s12_q; // shadow of analog 1/2 source
   wire emb_on = ctrl_q[mix_ch[3:2] + 3'd4];
   // shadow registers follow landed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= EAS_CTRL_RST;
         s12_q <= EAS_SRC12_RST;
      end else begin
         ctrl_q <= wr_ctrl ? pwdata[7:0] : ctrl_q;
         s12_q <= wr_anlg ? pwdata[2:0] : s12_q;
      end
   end
   // ====================
   // assertions
   a_ref_range: assert property (anlg_ref_db >= EAS_REF_MIN && anlg_ref_db <= EAS_REF_MAX)
      else $error("analog reference out of range");
   a_delay_clamp: assert property (wr_dly |-> ##2 delay_ms == $past(dly_w, 2))
      else $error("delay output not the clamped write");
   a_dbfs_follow: assert property (wr_ctrl |-> ##2 meter_dbfs == ctrl_q[EAS_CTRL_DBFS])
      else $error("meter scale not following control");
   a_dref_follow: assert property (wr_ctrl |-> ##2 dig_ref_18 == ctrl_q[EAS_CTRL_DREF])
      else $error("digital reference not following control");
   a_meter_point: assert property (mix_valid |=> meter_valid &&
      meter_data == ($past(ctrl_q[EAS_CTRL_PRE]) ? $past(mix_src) : $past(mix_out)))
      else $error("meter sample from wrong point");
   a_aes_every: assert property (mix_valid |=> aes_valid &&
      aes_ch == $past(mix_ch) && aes_data == $past(mix_out))
      else $error("digital path missed a mixer sample");
   a_strip_audio: assert property (pass_valid && $past(ctrl_q[EAS_CTRL_STRIP])
      |-> pass_is_data)
      else $error("audio passed while strip set");
   a_emb_group: assert property (mix_valid |=> emb_valid == $past(emb_on))
      else $error("embed output not matching group enable");
   a_anlg_pair: assert property (mix_valid && mix_ch[3:1] == s12_q |=> anlg_valid[0])
      else $error("analog pair 1/2 missed its source");
   // main scenarios reached
   c_dly_clamp: cover property (wr_dly && pwdata[9:0] > EAS_DELAY_MAX_MS);
   c_strip_pass: cover property (pass_valid && ctrl_q[EAS_CTRL_STRIP]);
   c_pre_meter: cover property (mix_valid && ctrl_q[EAS_CTRL_PRE]);
endmodule
bind eas_top eas_checker #(.SW(SW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .mix_valid, .mix_ch, .mix_src, .mix_out, .pass_valid,
   .pass_is_data, .emb_valid, .aes_valid, .aes_ch, .aes_data, .anlg_valid, .meter_valid,
   .meter_data, .meter_dbfs, .dig_ref_18, .anlg_ref_db, .delay_ms);

// [verif/eas_sdi_src.sv]
`timescale 1ns/1ps
// ====================
// serial video source on the link pins
module eas_sdi_src #(
   parameter int SW = 24
) (
   output logic lnk_clk,
   output logic lnk_valid,
   output logic [2:0] lnk_pair,
   output logic lnk_is_data,
   output logic lnk_locked,
   output logic lnk_field,
   output logic lnk_hd,
   output logic lnk_video,
   output logic [SW-1:0] lnk_data
);
   // idle: link clock stands low between packets
   initial begin
      {lnk_clk, lnk_valid, lnk_is_data, lnk_locked, lnk_field} = 5'h00;
      lnk_hd = 1'b1;
      lnk_video = 1'b1;
      lnk_pair = 3'h0;
      lnk_data = '0;
   end
   // one packet or field mark per link edge, 96 ns period
   task automatic send(input logic v, f, d, l, input logic [2:0] p, input logic [SW-1:0] x);
      lnk_valid = v;
      lnk_field = f;
      lnk_is_data = d;
      lnk_locked = l;
      lnk_pair = p;
      lnk_data = x;
      #32;
      lnk_clk = 1'b1;
      #32;
      lnk_clk = 1'b0;
      lnk_valid = 1'b0;
      lnk_field = 1'b0;
      lnk_pair = ~p; // released lines show no stale value
      lnk_data = ~x;
      lnk_is_data = ~d;
      lnk_locked = ~l;
      #32;
   endtask
   // line rate and video presence levels
   task automatic set_link(input logic hd, vid);
      lnk_hd = hd;
      lnk_video = vid;
   endtask
endmodule

// [verif/eas_top_test.sv]
`timescale 1ns/1ps
module eas_top_test;
   import eas_pkg::*;
   localparam int SW = 24;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, ctl;
   logic [31:0] pwdata, prdata, rd;
   logic lnk_clk, lnk_valid, lnk_is_data, lnk_locked, lnk_field, lnk_hd, lnk_video;
   logic [2:0] lnk_pair, pass_pair, s12, s34;
   logic [SW-1:0] lnk_data, pass_data, mix_src, mix_out, emb_data, aes_data, anlg_data;
   logic [SW-1:0] meter_data, xs, xo;
   logic [SW+3:0] last_pass; // pair, kind and payload of last kept packet
   logic pass_valid, pass_is_data, mix_valid, emb_valid, aes_valid, anlg_right, meter_valid;
   logic meter_dbfs, dig_ref_18;
   logic [3:0] mix_ch, emb_ch, aes_ch;
   logic [1:0] anlg_valid;
   logic signed [4:0] anlg_ref_db;
   logic [9:0] delay_ms, dv;
   logic [9:0] dl [4] = '{10'h000, 10'h3e8, 10'h3e9, 10'h3ff}; // delay corners
   logic signed [4:0] rl [4] = '{5'sh15, 5'sh16, 5'sh04, 5'sh05}; // level corners
   int error_cnt = 0;
   int n_checks = 0;
   int n_pass = 0;
   // ====================
   // clock, design and source
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   eas_top #(.SW(SW)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .lnk_clk, .lnk_valid, .lnk_pair, .lnk_is_data, .lnk_locked,
      .lnk_field, .lnk_hd, .lnk_video, .lnk_data, .pass_valid, .pass_pair, .pass_is_data,
      .pass_data, .mix_valid, .mix_ch, .mix_src, .mix_out, .emb_valid, .emb_ch, .emb_data,
      .aes_valid, .aes_ch, .aes_data, .anlg_valid, .anlg_right, .anlg_data, .meter_valid,
      .meter_data, .meter_dbfs, .dig_ref_18, .anlg_ref_db, .delay_ms);
   eas_sdi_src #(.SW(SW)) u_src (.lnk_clk, .lnk_valid, .lnk_pair, .lnk_is_data, .lnk_locked,
      .lnk_field, .lnk_hd, .lnk_video, .lnk_data);
   // counts kept packets
   always @(posedge pclk) begin
      if (pass_valid === 1'b1) begin
         n_pass <= n_pass + 1;
         last_pass <= {pass_pair, pass_is_data, pass_data};
      end
   end
   // ====================
   // helpers
   function automatic logic [9:0] dly_exp(input logic [9:0] v);
      return (v > EAS_DELAY_MAX_MS) ? EAS_DELAY_MAX_MS : v;
   endfunction
   function automatic logic signed [4:0] ref_exp(input logic signed [4:0] v);
      return (v < EAS_REF_MIN) ? EAS_REF_MIN : ((v > EAS_REF_MAX) ? EAS_REF_MAX : v);
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // apb transfer, holds until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one mixer sample, outputs one cycle later
   task automatic mix(input logic [3:0] ch);
      xs = SW'($urandom);
      xo = SW'($urandom);
      @(posedge pclk);
      mix_valid <= 1'b1;
      mix_ch <= ch;
      mix_src <= xs;
      mix_out <= xo;
      @(posedge pclk);
      mix_valid <= 1'b0;
      #1;
      chk("aes", {aes_valid, aes_ch, aes_data}, {1'b1, ch, xo});
      chk("meter", {meter_valid, meter_data}, {1'b1, ctl[EAS_CTRL_PRE] ? xs : xo});
      chk("emb", emb_valid, ctl[ch[3:2] + 3'd4]);
      if (emb_valid === 1'b1) chk("emb_d", {emb_ch, emb_data}, {ch, xo});
      chk("anlg", anlg_valid, {ch[3:1] == s34, ch[3:1] == s12});
      if (anlg_valid !== 2'b00) chk("anlg_d", {anlg_right, anlg_data}, {ch[0], xo});
   endtask
   // settings write and read back
   task automatic cfg(input logic [7:0] c, input logic [2:0] a, b, input logic signed [4:0] r);
      ctl = c;
      s12 = a;
      s34 = b;
      apb(1'b1, EAS_OFF_CTRL, {24'h0, c});
      apb(1'b1, EAS_OFF_ANLG, {19'h0, r, 1'b0, b, 1'b0, a});
      apb(1'b0, EAS_OFF_ANLG, 32'h0);
      chk("anlg_reg", rd, {19'h0, ref_exp(r), 1'b0, b, 1'b0, a});
      chk("ref_out", anlg_ref_db, ref_exp(r));
      apb(1'b0, EAS_OFF_CTRL, 32'h0);
      chk("ctrl_reg", rd, {24'h0, c});
      chk("dbfs", meter_dbfs, c[EAS_CTRL_DBFS]);
      chk("dref", dig_ref_18, c[EAS_CTRL_DREF]);
   endtask
   // ====================
   // sequence
   initial begin
      {presetn, psel, penable, pwrite, mix_valid} = 5'h00;
      {paddr, pwdata, mix_ch, mix_src, mix_out} = '0;
      void'($urandom(32'h570314af));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, EAS_OFF_ANLG, 32'h0);
      chk("anlg_rst", rd, {19'h0, EAS_REF_RST, 1'b0, EAS_SRC34_RST, 1'b0, EAS_SRC12_RST});
      apb(1'b0, EAS_OFF_CTRL, 32'h0);
      chk("pre_rst", rd[EAS_CTRL_PRE], 1'b0);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", err, 1'b1);
      for (int i = 0; i < 6; i++) begin
         dv = (i < 4) ? dl[i] : 10'($urandom);
         apb(1'b1, EAS_OFF_DELAY, {22'h0, dv});
         apb(1'b0, EAS_OFF_DELAY, 32'h0);
         chk("delay", rd, {22'h0, dly_exp(dv)});
         chk("delay_out", delay_ms, dly_exp(dv));
      end
      for (int r = 0; r < 4; r++) begin
         cfg(8'($urandom) & 8'hfe, 3'($urandom), 3'($urandom), rl[r]);
         for (int c = 0; c < 16; c++) mix(4'(c));
      end
      cfg(8'h00, 3'h0, 3'h1, 5'sh04);
      u_src.send(1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 24'h00_a001);
      u_src.send(1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 24'h00_b002);
      u_src.send(1'b1, 1'b0, 1'b0, 1'b0, 3'h3, 24'h00_c003);
      chk("pass_cnt", n_pass, 32'h3);
      chk("pass_last", last_pass, {3'h3, 1'b0, 24'h00_c003});
      apb(1'b0, EAS_OFF_KIND, 32'h0);
      chk("kind", rd, 32'h0000_0046);
      apb(1'b0, EAS_OFF_STAT, 32'h0);
      chk("stat", rd, 32'h0000_0303);
      apb(1'b1, EAS_OFF_CTRL, 32'h0000_0010);
      apb(1'b0, EAS_OFF_STAT, 32'h0);
      chk("confl", rd[EAS_STAT_CONFL], 1'b1);
      apb(1'b1, EAS_OFF_CTRL, 32'h0000_0011);
      apb(1'b0, EAS_OFF_STAT, 32'h0);
      chk("no_confl", rd[EAS_STAT_CONFL], 1'b0);
      u_src.send(1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 24'h00_d004);
      u_src.send(1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 24'h00_e005);
      chk("strip_cnt", n_pass, 32'h4);
      chk("strip_last", last_pass, {3'h0, 1'b1, 24'h00_e005});
      u_src.set_link(1'b0, 1'b1);
      repeat (2) u_src.send(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 24'h00_0000);
      apb(1'b0, EAS_OFF_KIND, 32'h0);
      chk("kind_gone", rd, 32'h0);
      apb(1'b0, EAS_OFF_STAT, 32'h0);
      chk("stat_sd", rd, 32'h0000_0200);
      u_src.set_link(1'b0, 1'b0);
      u_src.send(1'b1, 1'b0, 1'b1, 1'b1, 3'h2, 24'h00_f006);
      chk("novid_cnt", n_pass, 32'h4);
      apb(1'b0, EAS_OFF_STAT, 32'h0);
      chk("stat_novid", rd, 32'h0000_0004);
      wrap_up;
   end
   // hang guard
   initial begin
      #50us;
      error_cnt++;
      wrap_up;
   end
endmodule
